//--- src/opet_timer.v
// Purpose: timer channel with single-shot, retriggerable single-shot and quadrature encoder counting
// Assumes: inputs are raw pins; one kernel clock aclk; prescaler fixed at zero
// Notes:   register access over AXI4-Lite; reference output of channel 1 on a pin
`default_nettype none
`include "opet_map.vh"

// Contract
// - single-shot set halts counter at next update; clear runs repetitively; the halt comes only at a wrap, and never in encoder modes.
// - trigger mode with source code 00110 starts counter on input-two edge.
// - channel-2 select 01 routes filtered input two; zero polarities mean rising edge.
// - single-shot delay equals compare; pulse length equals reload minus compare.
// - PWM mode 2 reference rises on compare match, falls at reload value.
// - trigger edge sets count enable in hardware, starting the count.
// - fast enable forces reference to match level on trigger, PWM modes only.
// - retriggerable mode needs slave code 1000 and output code 1000 or 1001.
// - retriggerable pulse starts at trigger, extended by a new trigger.
// - four-bit output and slave mode fields are split and reassembled.
// - encoder slave codes 001, 010, 011 select edges counted.
// - input-one edge direction set by input-two level; ignored in two-only mode.
// - input-two edge direction set by input-one level; ignored in one-only mode.
// - direction bit updates on every input transition while counting enabled.
// - encoder counter wraps between 0 and reload value in either direction.
// - remap makes counter read bit 31 mirror update flag with no latency.
// - with remap, reads show flag in bit 31; counter top bit stays writable.
module opet_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        input_one_pin,
  input  wire        input_two_pin,
  output reg         channel_reference_output
);
  reg  [31:0] ctrl_r;
  reg  [31:0] slave_r;
  reg  [31:0] chan_r;
  reg  [31:0] counter_value_r;
  reg  [31:0] auto_reload_value_r;
  reg  [31:0] reload_pre_r;
  reg  [31:0] channel_compare_value_r;
  reg  [31:0] compare_pre_r;
  reg         update_interrupt_flag_r;
  reg         trig_flag_r;
  reg         in1_prev_r;
  reg         in2_prev_r;
  reg  [31:0] rd_data;
  reg         rd_ok;
  reg         wr_ok;
  reg         fast_hold_r;

  wire        in1_sync;
  wire        in2_sync;
  wire        wr_stb;
  wire [4:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [4:0]  rd_addr;

  opet_sync u_sync1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (input_one_pin),
    .level_r (in1_sync)
  );

  opet_sync u_sync2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (input_two_pin),
    .level_r (in2_sync)
  );

  opet_axil u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // decoded fields
  wire [3:0] slave_mode_select = {slave_r[`OPET_SLV_SMS3],
                                  slave_r[`OPET_SLV_SMS_HI:`OPET_SLV_SMS_LO]};
  wire [4:0] trigger_source_select = {slave_r[`OPET_SLV_TS43_HI:`OPET_SLV_TS43_LO],
                                      slave_r[`OPET_SLV_TS_HI:`OPET_SLV_TS_LO]};
  wire [3:0] channel1_output_mode = {chan_r[`OPET_CH_OCM3],
                                     chan_r[`OPET_CH_OCM_HI:`OPET_CH_OCM_LO]};
  wire [1:0] channel2_selection = chan_r[`OPET_CH_C2S_HI:`OPET_CH_C2S_LO];
  wire       count_enable_bit = ctrl_r[`OPET_CTRL_CEN];
  wire       dir_down = ctrl_r[`OPET_CTRL_DIR];
  wire       single_shot_select = ctrl_r[`OPET_CTRL_SSHOT];
  wire       flag_remap_enable = ctrl_r[`OPET_CTRL_REMAP];
  wire       fast_output_enable = chan_r[`OPET_CH_FE];

  // polarity-adjusted filtered inputs
  wire filtered_input_one = in1_sync ^ chan_r[`OPET_CH_C1P];
  wire filtered_input_two = in2_sync ^ chan_r[`OPET_CH_C2P];
  wire in1_rise = filtered_input_one & ~in1_prev_r;
  wire in1_fall = ~filtered_input_one & in1_prev_r;
  wire in2_rise = filtered_input_two & ~in2_prev_r;
  wire in2_fall = ~filtered_input_two & in2_prev_r;

  wire enc_mode = (slave_mode_select == `OPET_SMS_ENC2) || (slave_mode_select == `OPET_SMS_ENC1) ||
                  (slave_mode_select == `OPET_SMS_ENC12);
  wire cnt1 = (slave_mode_select == `OPET_SMS_ENC1) || (slave_mode_select == `OPET_SMS_ENC12);
  wire cnt2 = (slave_mode_select == `OPET_SMS_ENC2) || (slave_mode_select == `OPET_SMS_ENC12);
  // direction for the counted edge: 1 means down
  wire e1_dn = (in1_rise & filtered_input_two) | (in1_fall & ~filtered_input_two);
  wire e2_dn = (in2_rise & ~filtered_input_one) | (in2_fall & filtered_input_one);
  wire e1 = in1_rise | in1_fall;
  wire e2 = in2_rise | in2_fall;
  wire enc_step = enc_mode && count_enable_bit && ((cnt1 && e1) || (cnt2 && e2));

  // trigger from input two through channel-2 mapping
  wire slave_trigger_input = (trigger_source_select == `OPET_TS_IN2) &&
                             (channel2_selection == `OPET_C2S_DIRECT) && in2_rise;
  wire trig_start = slave_trigger_input && (slave_mode_select == `OPET_SMS_TRIG);
  wire trig_retrig = slave_trigger_input && (slave_mode_select == `OPET_SMS_RSTTRIG);
  wire pwm_mode = (channel1_output_mode == `OPET_OCM_PWM1) || (channel1_output_mode == `OPET_OCM_PWM2);
  wire retrig_mode = (channel1_output_mode == `OPET_OCM_RTOPM1) ||
                     (channel1_output_mode == `OPET_OCM_RTOPM2);

  wire ug_wr = wr_stb && (wr_addr == `OPET_OFF_EVENT) && wr_strb[0] && wr_data[`OPET_EV_UG];
  wire at_top = (counter_value_r == auto_reload_value_r);
  wire at_zero = (counter_value_r == 32'h00000000);
  // free-running tick in time-base modes; encoder steps otherwise
  wire tick = enc_mode ? enc_step : count_enable_bit;
  wire step_dn = enc_mode ? ((cnt1 && e1) ? e1_dn : e2_dn) : dir_down;
  wire wrap = tick && (step_dn ? at_zero : at_top);
  wire update_event = wrap || ug_wr || trig_retrig;
  wire pwm_match = fast_hold_r || (counter_value_r >= channel_compare_value_r);

  always @* begin
    wr_ok = 1'b1;
    case (wr_addr)
      `OPET_OFF_CTRL, `OPET_OFF_SLAVE, `OPET_OFF_CHAN, `OPET_OFF_STATUS, `OPET_OFF_EVENT,
      `OPET_OFF_COUNT, `OPET_OFF_RELOAD, `OPET_OFF_COMPARE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @* begin
    rd_ok = 1'b1;
    case (rd_addr)
      `OPET_OFF_CTRL:    rd_data = ctrl_r;
      `OPET_OFF_SLAVE:   rd_data = slave_r;
      `OPET_OFF_CHAN:    rd_data = chan_r;
      `OPET_OFF_STATUS:  rd_data = {30'h00000000, trig_flag_r, update_interrupt_flag_r};
      `OPET_OFF_EVENT:   rd_data = 32'h00000000;
      `OPET_OFF_COUNT:   rd_data = flag_remap_enable ?
                                   {update_interrupt_flag_r, counter_value_r[30:0]} :
                                   counter_value_r;
      `OPET_OFF_RELOAD:  rd_data = reload_pre_r;
      `OPET_OFF_COMPARE: rd_data = compare_pre_r;
      default: begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r                  <= 32'h00000000;
      slave_r                 <= 32'h00000000;
      chan_r                  <= 32'h00000000;
      counter_value_r         <= 32'h00000000;
      auto_reload_value_r     <= `OPET_RST_RELOAD;
      reload_pre_r            <= `OPET_RST_RELOAD;
      channel_compare_value_r <= 32'h00000000;
      compare_pre_r           <= 32'h00000000;
      update_interrupt_flag_r <= 1'b0;
      trig_flag_r             <= 1'b0;
      in1_prev_r              <= 1'b0;
      in2_prev_r              <= 1'b0;
    end else begin
      in1_prev_r <= filtered_input_one;
      in2_prev_r <= filtered_input_two;
      if (wr_stb) begin
        case (wr_addr)
          `OPET_OFF_CTRL:    ctrl_r <= merge(ctrl_r, wr_data, wr_strb);
          `OPET_OFF_SLAVE:   slave_r <= merge(slave_r, wr_data, wr_strb);
          `OPET_OFF_CHAN:    chan_r <= merge(chan_r, wr_data, wr_strb);
          `OPET_OFF_STATUS: begin
            // write zero clears
            if (wr_strb[0] && !wr_data[0]) begin
              update_interrupt_flag_r <= 1'b0;
            end
            if (wr_strb[0] && !wr_data[1]) begin
              trig_flag_r <= 1'b0;
            end
          end
          `OPET_OFF_COUNT:   counter_value_r <= merge(counter_value_r, wr_data, wr_strb);
          `OPET_OFF_RELOAD: begin
            reload_pre_r <= merge(reload_pre_r, wr_data, wr_strb);
            if (!ctrl_r[`OPET_CTRL_RELOAD_PRELOAD_ENABLE]) begin
              auto_reload_value_r <= merge(reload_pre_r, wr_data, wr_strb);
            end
          end
          `OPET_OFF_COMPARE: begin
            compare_pre_r <= merge(compare_pre_r, wr_data, wr_strb);
            if (!chan_r[`OPET_CH_PE]) begin
              channel_compare_value_r <= merge(compare_pre_r, wr_data, wr_strb);
            end
          end
          default: ;
        endcase
      end
      if (slave_trigger_input) begin
        trig_flag_r <= 1'b1;
      end
      // hardware start on trigger
      if (trig_start || trig_retrig) begin
        ctrl_r[`OPET_CTRL_CEN] <= 1'b1;
      end
      // encoder direction follows every transition
      if (enc_mode && count_enable_bit && (e1 || e2)) begin
        ctrl_r[`OPET_CTRL_DIR] <= e1 ? e1_dn : e2_dn;
      end
      // counter
      if (ug_wr || trig_retrig) begin
        counter_value_r <= (dir_down && !enc_mode) ? reload_pre_r : 32'h00000000;
      end else if (tick) begin
        if (step_dn) begin
          counter_value_r <= at_zero ? auto_reload_value_r : counter_value_r - 32'h00000001;
        end else begin
          counter_value_r <= at_top ? 32'h00000000 : counter_value_r + 32'h00000001;
        end
      end
      if (update_event) begin
        auto_reload_value_r     <= reload_pre_r;
        channel_compare_value_r <= compare_pre_r;
        if (wrap) begin
          update_interrupt_flag_r <= 1'b1;
        end
      end
      // single-shot stop at wrap, wins over the trigger start and CTRL writes
      if (wrap && single_shot_select && !enc_mode) begin
        ctrl_r[`OPET_CTRL_CEN] <= 1'b0;
      end
    end
  end

  // reference output: PWM and retriggerable single-shot
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_reference_output <= 1'b0;
      fast_hold_r              <= 1'b0;
    end else begin
      // fast start keeps the match level until the update ends the pulse
      if (pwm_mode && fast_output_enable && trig_start) begin
        fast_hold_r <= 1'b1;
      end else if (wrap || !pwm_mode) begin
        fast_hold_r <= 1'b0;
      end
      if (retrig_mode) begin
        if (trig_retrig) begin
          channel_reference_output <= (channel1_output_mode == `OPET_OCM_RTOPM1);
        end else if (!count_enable_bit || wrap) begin
          channel_reference_output <= (channel1_output_mode == `OPET_OCM_RTOPM2);
        end
      end else if (pwm_mode) begin
        if (fast_output_enable && trig_start) begin
          channel_reference_output <= (channel1_output_mode == `OPET_OCM_PWM2);
        end else if (channel1_output_mode == `OPET_OCM_PWM2) begin
          // mode 2: high from compare, low again once the counter reaches reload
          channel_reference_output <= pwm_match && !at_top;
        end else begin
          channel_reference_output <= !pwm_match;
        end
      end
    end
  end
endmodule // opet_timer
`default_nettype wire

//--- include/opet_map.vh
// Purpose: register offsets, field positions, reset values and codes for the pulse/encoder timer
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   offsets and field layout are local choices
`ifndef OPET_MAP_VH
`define OPET_MAP_VH

`define OPET_OFF_CTRL      5'h00
`define OPET_OFF_SLAVE     5'h04
`define OPET_OFF_CHAN      5'h08
`define OPET_OFF_STATUS    5'h0C
`define OPET_OFF_EVENT     5'h10
`define OPET_OFF_COUNT     5'h14
`define OPET_OFF_RELOAD    5'h18
`define OPET_OFF_COMPARE   5'h1C

// control register bits
`define OPET_CTRL_CEN      0
`define OPET_CTRL_DIR      4
`define OPET_CTRL_SSHOT    3
`define OPET_CTRL_CMS_LO   5
`define OPET_CTRL_CMS_HI   6
`define OPET_CTRL_RELOAD_PRELOAD_ENABLE     7
`define OPET_CTRL_REMAP    11
// slave register bits
`define OPET_SLV_SMS_LO    0
`define OPET_SLV_SMS_HI    2
`define OPET_SLV_TS_LO     4
`define OPET_SLV_TS_HI     6
`define OPET_SLV_SMS3      16
`define OPET_SLV_TS43_LO   20
`define OPET_SLV_TS43_HI   21
// channel register bits
`define OPET_CH_C2S_LO     8
`define OPET_CH_C2S_HI     9
`define OPET_CH_FE         2
`define OPET_CH_PE         3
`define OPET_CH_OCM_LO     4
`define OPET_CH_OCM_HI     6
`define OPET_CH_OCM3       16
`define OPET_CH_C1P        20
`define OPET_CH_C1NP       21
`define OPET_CH_C2P        22
`define OPET_CH_C2NP       23
// event register bits
`define OPET_EV_UG         0

`define OPET_SMS_ENC2      4'h1
`define OPET_SMS_ENC1      4'h2
`define OPET_SMS_ENC12     4'h3
`define OPET_SMS_TRIG      4'h6
`define OPET_SMS_RSTTRIG   4'h8
`define OPET_TS_IN2        5'h06
`define OPET_C2S_DIRECT    2'h1
`define OPET_OCM_PWM1      4'h6
`define OPET_OCM_PWM2      4'h7
`define OPET_OCM_RTOPM1    4'h8
`define OPET_OCM_RTOPM2    4'h9

`define OPET_RST_RELOAD    32'hFFFFFFFF
`define OPET_SYNC_STAGES   3

`endif

//--- src/opet_sync.v
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to aclk
// Notes:   output changes once stages two and three agree
`default_nettype none
module opet_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin_in,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // opet_sync
`default_nettype wire

//--- src/opet_axil.v
// Purpose: AXI4-Lite slave front end producing single-cycle register strobes
// Assumes: one write and one read at a time
// Notes:   unmapped addresses are decided by the caller via wr_ok/rd_ok
`default_nettype none
module opet_axil (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         wr_stb,
  output reg  [4:0]  wr_addr,
  output reg  [31:0] wr_data,
  output reg  [3:0]  wr_strb,
  input  wire        wr_ok,
  output wire [4:0]  rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);
  reg aw_have_r;
  reg w_have_r;
  reg [4:0] ar_addr_r;
  reg ar_have_r;

  assign rd_addr = ar_addr_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      wr_stb        <= 1'b0;
      wr_addr       <= 5'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      wr_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid && !wr_stb) begin
        wr_stb <= 1'b1;
      end
      if (wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
      ar_addr_r     <= 5'h00;
      ar_have_r     <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r     <= s_axi_araddr;
        ar_have_r     <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (ar_have_r) begin
        ar_have_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_data : 32'h00000000;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // opet_axil
`default_nettype wire

//--- tb/opet_timer_sva.sv
// Purpose: bus handshake checks on the timer ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to opet_timer below
`default_nettype none
module opet_timer_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##3 s_axi_bvalid) else $error("write answer not on time");
  a_rd_answer: assert property (s_rd_taken |-> ##2 s_axi_rvalid) else $error("read answer not on time");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid not dropped");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid not dropped");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted in flight");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
  a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad rresp");
endmodule // opet_timer_sva
bind opet_timer opet_timer_sva opet_timer_sva_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

//--- tb/opet_quad_src.sv
// Purpose: quadrature encoder and trigger source on the timer pins
// Assumes: steps are slow against the pin synchroniser
// Notes:   pins change just after a rising edge
`default_nettype none
module opet_quad_src (
  input  wire logic aclk,
  output var logic  input_one_pin,
  output var logic  input_two_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    input_one_pin = 1'b0;
    input_two_pin = 1'b0;
  end
  // one gray step, phase one leads when counting up
  task automatic step(input bit up, input int gap);
    @(posedge aclk);
    if ((input_one_pin == input_two_pin) == up) input_one_pin <= ~input_one_pin;
    else input_two_pin <= ~input_two_pin;
    repeat (gap) @(posedge aclk);
  endtask
  // n pulses on input two, rising edges hi+gap+1 cycles apart
  task automatic trig(input int hi, input int n, input int gap);
    repeat (n) begin
      @(posedge aclk);
      input_two_pin <= 1'b1;
      repeat (hi) @(posedge aclk);
      input_two_pin <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
  endtask
endmodule // opet_quad_src
`default_nettype wire

//--- tb/opet_timer_tb.sv
// Purpose: self-checking bench for the pulse and encoder timer
// Assumes: 250 MHz aclk, AXI4-Lite master, one request at a time
// Notes:   pins come from the quadrature source model
`default_nettype none
`include "opet_map.vh"
module opet_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        input_one_pin, input_two_pin, channel_reference_output;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_total, n_compared, cyc;
  opet_timer opet_timer_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .input_one_pin, .input_two_pin, .channel_reference_output
  );
  opet_quad_src opet_quad_src_inst (.aclk, .input_one_pin, .input_two_pin);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, 32'h0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input bit cmp = 1);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (cmp) chk(rd, exp);
  endtask
  // trigger n times in the background while timing the delay and the length of the pulse
  task automatic pulse(input logic idle, input int n, output int d, output int w);
    d = 0;
    w = 0;
    fork
      opet_quad_src_inst.trig(3, n, 6);
    join_none
    while (channel_reference_output === idle && d < 300) begin
      @(posedge aclk);
      d++;
    end
    while (channel_reference_output === ~idle && w < 300) begin
      @(posedge aclk);
      w++;
    end
  endtask
  task automatic t_single();
    int d[3], w[3];
    wr(`OPET_OFF_RELOAD, 32'h14);
    wr(`OPET_OFF_SLAVE, 32'h66);
    for (int i = 0; i < 3; i++) begin
      wr(`OPET_OFF_COMPARE, i == 0 ? 32'h5 : 32'h9);
      wr(`OPET_OFF_CHAN, i == 2 ? 32'h174 : 32'h170);
      wr(`OPET_OFF_CTRL, 32'h8);
      wr(`OPET_OFF_EVENT, 32'h1);
      pulse(1'b0, 1, d[i], w[i]);
      if (i < 2) chk(w[i], i == 0 ? 32'hF : 32'hB);
    end
    chk(d[1] - d[0], 32'h4);
    chk(d[2] < d[1], 32'h1);
    rchk(`OPET_OFF_COUNT, 0, 0);
    repeat (20) @(posedge aclk);
    rchk(`OPET_OFF_COUNT, rd);
    rchk(`OPET_OFF_CTRL, 32'h8);
  endtask
  task automatic t_retrig();
    int d0, w0, w1;
    wr(`OPET_OFF_COMPARE, 32'h0);
    wr(`OPET_OFF_SLAVE, 32'h10060);
    for (int m = 0; m < 2; m++) begin
      wr(`OPET_OFF_CHAN, m == 1 ? 32'h10110 : 32'h10100);
      wr(`OPET_OFF_CTRL, 32'h8);
      wr(`OPET_OFF_EVENT, 32'h1);
      pulse(m[0], 1, d0, w0);
      chk(d0 < 9, 32'h1);
      pulse(m[0], 2, d0, w1);
      chk(w1 - w0, 32'hA);
    end
  endtask
  task automatic t_enc();
    logic [31:0] e;
    wr(`OPET_OFF_RELOAD, 32'h7);
    wr(`OPET_OFF_CHAN, 32'h100);
    for (int m = 1; m < 4; m++) begin
      e = m == 3 ? 32'h4 : 32'h2;
      wr(`OPET_OFF_SLAVE, 32'(m));
      wr(`OPET_OFF_CTRL, 32'h1);
      wr(`OPET_OFF_EVENT, 32'h1);
      repeat (4) opet_quad_src_inst.step(1'b1, 8);
      rchk(`OPET_OFF_COUNT, e);
      rchk(`OPET_OFF_CTRL, 32'h1);
      repeat (8) opet_quad_src_inst.step(1'b0, 8);
      rchk(`OPET_OFF_COUNT, 32'h8 - e);
      rchk(`OPET_OFF_CTRL, 32'h11);
    end
  endtask
  task automatic t_remap();
    wr(`OPET_OFF_CTRL, 32'h800);
    wr(`OPET_OFF_SLAVE, 32'h0);
    wr(`OPET_OFF_STATUS, 32'h0);
    wr(`OPET_OFF_COUNT, 32'h80000002);
    rchk(`OPET_OFF_COUNT, 32'h2);
    wr(`OPET_OFF_CTRL, 32'h0);
    rchk(`OPET_OFF_COUNT, 32'h80000002);
    wr(`OPET_OFF_COUNT, 32'h0);
    wr(`OPET_OFF_RELOAD, 32'h3);
    wr(`OPET_OFF_CTRL, 32'h801);
    repeat (12) @(posedge aclk);
    wr(`OPET_OFF_CTRL, 32'h800);
    rchk(`OPET_OFF_COUNT, 0, 0);
    chk(rd[31], 32'h1);
    wr(`OPET_OFF_STATUS, 32'h0);
    rchk(`OPET_OFF_COUNT, 0, 0);
    chk(rd[31], 32'h0);
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {err_total, n_compared, cyc} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`OPET_OFF_RELOAD, 32'hFFFFFFFF);
    rchk(`OPET_OFF_CTRL, 32'h0);
    t_single();
    t_retrig();
    t_enc();
    t_remap();
    print_verdict();
  end
endmodule // opet_timer_tb
`default_nettype wire
